/* File: bench/fgs_battery_model.sv */
// battery cell and sense front end as seen by the converter
module fgs_battery_model (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        adc_sample,
	input  wire logic        charge,
	input  wire logic [11:0] cur_level,
	output logic      [11:0] adc_voltage,
	output logic      [11:0] instant_current,
	output logic             charging_pin,
	output logic      [11:0] thermistor_node
);
	timeunit 1ns;
	timeprecision 1ns;
	// cell voltage climbs on each sample while charging, dropping back to 12'h900 once past 12'hf00
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_voltage <= 12'h900;
		end else if (adc_sample && charge) begin
			adc_voltage <= (adc_voltage > 12'hf00) ? 12'h900 : adc_voltage + 12'h040;
		end
	end
	// sense levels come from the bench; thermistor sits mid range
	assign instant_current = cur_level;
	assign charging_pin    = charge;
	assign thermistor_node = 12'h800;
endmodule

/* File: bench/fgs_fuel_gauge_bench.sv */
module fgs_fuel_gauge_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TD = 10;
	localparam logic [3:0] RA [5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
	localparam logic [31:0] RM [5] = '{32'h0000_0700, 32'h0000_0fff, 32'h0000_ffff, 32'h0fff_0fff, 32'hffff_ffff};
	localparam logic [31:0] RV [5] = '{32'h0000_0100, 32'h0000_0fff, 32'h0000_0064, 32'h0400_0c00, 32'h0};
	logic        ref_clk;
	logic        rst_n;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [11:0] adc_voltage;
	logic [11:0] instant_current;
	logic        charging_pin;
	logic [11:0] thermistor_node;
	logic        adc_enable;
	logic        adc_sample;
	logic        accumulator_overflow_irq;
	logic        irq;
	logic        charge;
	logic [11:0] cur_level;
	logic [31:0] q;
	int          c;
	int          failures;
	int          total_checks;
	fgs_fuel_gauge #(.TICK_DIV(TD)) DUT (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .adc_voltage, .instant_current,
		.charging_pin, .thermistor_node, .adc_enable, .adc_sample, .accumulator_overflow_irq, .irq);
	fgs_battery_model u_batt (.ref_clk, .rst_n, .adc_sample, .charge, .cur_level,
		.adc_voltage, .instant_current, .charging_pin, .thermistor_node);
	// clock at 25 MHz
	always begin
		#20 ref_clk = ~ref_clk;
	end
	// ****
	// reporting and bus tasks
	// ****
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic err(input string m);
		failures++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		total_checks++;
		if (g !== e) begin
			err(m);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address   <= a;
		avs_write     <= w;
		avs_read      <= !w;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
			n++;
			if (n > 20) begin
				err("bus hang");
				stop_test();
			end
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// cycles until the next sample pulse
	task automatic smp(input int lim);
		c = 0;
		do begin
			@(negedge ref_clk);
			c++;
			if (c > lim) begin
				err("no sample");
				stop_test();
			end
		end while (adc_sample !== 1'b1);
	endtask
	// ****
	// test sequence
	// ****
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		charge = 1'b0;
		cur_level = 12'h010;
		failures = 0;
		total_checks = 0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, RA[i], 32'h0);
			chk(q & RM[i], RV[i], "reset value");
		end
		repeat (300) @(negedge ref_clk);
		chk(32'(adc_enable), 32'h0, "converter on in shutdown");
		$display("test reset done");
		bus(1'b1, 4'h0, 32'h0000_0001);
		smp(2000);
		smp(2000);
		chk(32'(c), 32'(10 * TD), "active gap");
		bus(1'b0, 4'h0, 32'h0);
		chk(q & 32'h0000_0700, 32'h0000_0200, "not active");
		$display("test active done");
		for (int r = 0; r < 4; r++) begin
			bus(1'b1, 4'h0, 32'h3 | (32'(r) << 2));
			smp(7000);
			smp(7000);
			chk(32'(c), 32'((75 << r) * TD), "sleep gap");
			repeat (5) @(negedge ref_clk);
			chk(32'(adc_enable), 32'h0, "converter on between samples");
		end
		bus(1'b0, 4'h0, 32'h0);
		chk(q & 32'h0000_0700, 32'h0000_0400, "not sleeping");
		$display("test sleep done");
		cur_level <= 12'h200;
		bus(1'b1, 4'h0, 32'h0000_0003);
		bus(1'b1, 4'h1, 32'h0000_0100);
		smp(1000);
		smp(1000);
		repeat (4) @(negedge ref_clk);
		bus(1'b0, 4'h0, 32'h0);
		chk(q & 32'h0000_0700, 32'h0000_0200, "no wake");
		bus(1'b0, 4'h4, 32'h0);
		chk(q & 32'h0000_ffff, 32'h0000_1919, "soc not from voltage");
		$display("test wake done");
		bus(1'b1, 4'h0, 32'h0000_0011);
		bus(1'b1, 4'h2, 32'h0000_1234);
		bus(1'b0, 4'h2, 32'h0);
		chk(q & 32'h0000_ffff, 32'h0000_0064, "capacity not locked");
		bus(1'b1, 4'h0, 32'h0000_0061);
		bus(1'b1, 4'h2, 32'h0000_0050);
		bus(1'b0, 4'h2, 32'h0);
		chk(q & 32'h0000_ffff, 32'h0000_0050, "capacity write lost");
		$display("test capacity done");
		bus(1'b1, 4'h0, 32'h0000_0071);
		bus(1'b1, 4'h7, 32'h0000_0001);
		bus(1'b1, 4'h3, 32'h0000_4010);
		bus(1'b1, 4'h5, 32'h0000_0ffe);
		charge <= 1'b1;
		c = 0;
		while (accumulator_overflow_irq !== 1'b1) begin
			@(negedge ref_clk);
			c++;
			if (c > 40000) begin
				err("no overflow");
				stop_test();
			end
		end
		charge <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk(32'(irq), 32'h1, "irq low");
		bus(1'b0, 4'h5, 32'h0);
		chk(32'(q[11:0] < 12'h064), 32'h1, "no wrap");
		bus(1'b0, 4'h2, 32'h0);
		chk(q & 32'h0000_ffff, 32'h0000_004b, "capacity not aged");
		bus(1'b1, 4'h7, 32'h0);
		repeat (3) @(negedge ref_clk);
		chk(32'(irq), 32'h0, "masked irq high");
		chk(32'(accumulator_overflow_irq), 32'h1, "flag dropped");
		bus(1'b1, 4'h6, 32'h0000_0001);
		repeat (3) @(negedge ref_clk);
		chk(32'(accumulator_overflow_irq), 32'h0, "flag not cleared");
		$display("test overflow done");
		stop_test();
	end
endmodule

/* File: bench/fgs_fuel_gauge_properties.sv */
module fgs_fuel_gauge_properties #(
	parameter int TICK_DIV = 10
) (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [11:0] adc_voltage,
	input wire logic [11:0] instant_current,
	input wire logic        charging_pin,
	input wire logic [11:0] thermistor_node,
	input wire logic        adc_enable,
	input wire logic        adc_sample,
	input wire logic        accumulator_overflow_irq,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        en_m;
	logic        slp_m;
	logic        msk_m;
	logic        woke;
	logic        vld;
	logic [1:0]  rate_m;
	logic [11:0] lim_m;
	int          gap;
	int          wcnt;
	logic        cwr;
	logic        wake_now;
	logic        clr;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ****
	// mirrors of host settings and sample spacing
	// ****
	assign cwr      = avs_write && !avs_waitrequest && avs_address == fgs_pkg::ADDR_CTRL;
	assign clr      = avs_write && avs_address == fgs_pkg::ADDR_IRQ && avs_writedata[0];
	assign wake_now = adc_sample && en_m && slp_m && !woke && instant_current > lim_m;
	// copies of control, threshold and mask
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_m   <= 1'b0;
			slp_m  <= 1'b0;
			rate_m <= 2'h0;
			lim_m  <= 12'hfff;
			msk_m  <= 1'b0;
		end else begin
			if (cwr) begin
				en_m   <= avs_writedata[0];
				slp_m  <= avs_writedata[1];
				rate_m <= avs_writedata[3:2];
			end
			if (avs_write && avs_address == fgs_pkg::ADDR_WAKE) lim_m <= avs_writedata[11:0];
			if (avs_write && avs_address == fgs_pkg::ADDR_MASK) msk_m <= avs_writedata[0];
		end
	end
	// gap since last sample; a control write or a wake restarts tracking
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap  <= 0;
			wcnt <= 0;
			vld  <= 1'b0;
			woke <= 1'b0;
		end else begin
			gap  <= adc_sample ? 1 : gap + 1;
			wcnt <= cwr ? 0 : (wcnt < 15 ? wcnt + 1 : wcnt);
			vld  <= !cwr && !wake_now && (vld || adc_sample);
			woke <= !cwr && (woke || wake_now);
		end
	end
	// ****
	// properties
	// ****
	property p_off; !en_m && wcnt > 3 |-> !adc_enable && !adc_sample; endproperty
	property p_pulse; adc_sample |=> !adc_sample; endproperty
	property p_act; adc_sample && vld && en_m && !slp_m |-> gap == 10 * TICK_DIV; endproperty
	property p_slp; adc_sample && vld && en_m && slp_m && !woke |-> gap == (75 << rate_m) * TICK_DIV; endproperty
	property p_duty; en_m && slp_m && !woke && wcnt > 3 && adc_enable |-> adc_sample; endproperty
	property p_wake; wake_now |-> ##2 adc_enable [*4]; endproperty
	property p_sticky; accumulator_overflow_irq && !clr |=> accumulator_overflow_irq; endproperty
	property p_irq; accumulator_overflow_irq && msk_m |-> ##[0:1] irq; endproperty
	a_off: assert property (p_off) else $error("converter busy while off");
	a_pulse: assert property (p_pulse) else $error("sample pulse too long");
	a_act: assert property (p_act) else $error("active sample gap wrong");
	a_slp: assert property (p_slp) else $error("sleep sample gap wrong");
	a_duty: assert property (p_duty) else $error("converter on between samples");
	a_wake: assert property (p_wake) else $error("no wake on high current");
	a_sticky: assert property (p_sticky) else $error("overflow flag dropped");
	a_irq: assert property (p_irq) else $error("unmasked flag without irq");
	c_wake: cover property (wake_now);
	c_ovf: cover property ($rose(accumulator_overflow_irq));
	c_slp: cover property (adc_sample && vld && slp_m);
endmodule

bind fgs_fuel_gauge fgs_fuel_gauge_properties #(.TICK_DIV(TICK_DIV)) u_props (
	.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
	.avs_waitrequest, .adc_voltage, .instant_current, .charging_pin, .thermistor_node,
	.adc_enable, .adc_sample, .accumulator_overflow_irq, .irq
);

/* File: hdl/fgs_fuel_gauge.sv */
// fuel gauge sequencer with avalon-mm register slave
module fgs_fuel_gauge #(
	parameter int TICK_DIV = fgs_pkg::TICK_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [11:0] adc_voltage,
	input  wire logic [11:0] instant_current,
	input  wire logic        charging_pin,
	input  wire logic [11:0] thermistor_node,
	output logic             adc_enable,
	output logic             adc_sample,
	output logic             accumulator_overflow_irq,
	output logic             irq
);
	// ****************************************
	// input synchronisers
	// ****************************************
	fgs_pkg::fgs_sample_type meta;
	fgs_pkg::fgs_sample_type smp;

	// two-stage capture of pin levels
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			smp  <= '0;
		end else begin
			meta <= '{adc_voltage, instant_current, charging_pin, thermistor_node};
			smp  <= meta;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [7:0]  ctrl;
	logic [11:0] sleep_exit_current_threshold;
	logic [15:0] battery_capacity_value;
	logic [7:0]  aging_reduction_proportion;
	logic [7:0]  temperature_adjust_proportion;
	logic [11:0] temp_low_limit;
	logic [11:0] temp_high_limit;
	logic [11:0] charge_accumulator;
	localparam int IRQ_W = fgs_pkg::IRQ_NUM;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [7:0]  soc;
	fgs_pkg::fgs_mode_type mode;
	logic        first_update;
	logic        rd_pending;

	logic wr_hit;
	logic rd_hit;
	logic acm_overflow;
	logic update_pulse;
	logic sample_pulse;

	// one-cycle wait on reads so data comes from a register
	assign wr_hit = avs_write;
	assign rd_hit = avs_read && rd_pending;
	assign avs_waitrequest = avs_read && !rd_pending;

	// read latency flag
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pending <= 1'b0;
		end else begin
			rd_pending <= avs_read && !rd_pending;
		end
	end

	// control register steering mode, rate and adjust enables
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= 8'h00;
		end else if (wr_hit && avs_address == fgs_pkg::ADDR_CTRL) begin
			ctrl <= avs_writedata[7:0];
		end
	end

	// configuration registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_exit_current_threshold  <= 12'hfff;
			aging_reduction_proportion    <= 8'h00;
			temperature_adjust_proportion <= 8'h00;
			temp_low_limit                <= fgs_pkg::TEMP_LO_RST;
			temp_high_limit               <= fgs_pkg::TEMP_HI_RST;
			irq_mask                      <= '0;
		end else if (wr_hit) begin
			unique case (avs_address)
				fgs_pkg::ADDR_WAKE: begin
					sleep_exit_current_threshold <= avs_writedata[11:0];
				end
				fgs_pkg::ADDR_ADJ: begin
					aging_reduction_proportion    <= avs_writedata[7:0];
					temperature_adjust_proportion <= avs_writedata[15:8];
				end
				fgs_pkg::ADDR_TLIM: begin
					temp_low_limit  <= avs_writedata[11:0];
					temp_high_limit <= avs_writedata[27:16];
				end
				fgs_pkg::ADDR_MASK: begin
					irq_mask <= avs_writedata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// time base and scheduler
	// ****************************************
	logic [$clog2(TICK_DIV)-1:0] div_cnt;
	logic        tick;
	logic [9:0]  sample_cnt;
	logic [13:0] update_cnt;
	logic [9:0]  sample_period;
	logic [13:0] update_period;
	logic [1:0]  rate_sel;

	assign rate_sel = ctrl[fgs_pkg::CTRL_RATE_LO +: 2];

	// period pair per mode and rate
	always_comb begin
		if (mode == fgs_pkg::FGS_ACTIVE) begin
			sample_period = 10'(fgs_pkg::ACT_SAMPLE_T);
			update_period = 14'(fgs_pkg::ACT_UPDATE_T);
		end else begin
			sample_period = 10'(fgs_pkg::SLP_SAMPLE_T) << rate_sel;
			update_period = (rate_sel == 2'b00) ? 14'(fgs_pkg::SLP_UPDATE_T)
				: 14'(fgs_pkg::SLP_UPDATE_T * 2) << rate_sel;
		end
	end

	// tenth-second enable pulse, cleared and held off in shutdown
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
			tick    <= 1'b0;
		end else if (mode == fgs_pkg::FGS_OFF) begin
			div_cnt <= '0;
			tick    <= 1'b0;
		end else begin
			tick    <= (div_cnt == ($clog2(TICK_DIV))'(TICK_DIV - 1));
			div_cnt <= (div_cnt == ($clog2(TICK_DIV))'(TICK_DIV - 1)) ? '0 : div_cnt + 1'b1;
		end
	end

	assign sample_pulse = tick && (sample_cnt >= sample_period - 10'h001);
	assign update_pulse = tick && (update_cnt >= update_period - 14'h0001);

	// sample and update interval counters
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_cnt <= '0;
			update_cnt <= '0;
		end else if (mode == fgs_pkg::FGS_OFF) begin
			sample_cnt <= '0;
			update_cnt <= '0;
		end else if (tick) begin
			sample_cnt <= sample_pulse ? '0 : sample_cnt + 10'h001;
			update_cnt <= update_pulse ? '0 : update_cnt + 14'h0001;
		end
	end

	// converter strobe; sleep keeps converter off between samples
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_sample <= 1'b0;
			adc_enable <= 1'b0;
		end else begin
			adc_sample <= sample_pulse;
			adc_enable <= (mode == fgs_pkg::FGS_ACTIVE) || sample_pulse;
		end
	end

	// ****************************************
	// mode machine
	// ****************************************
	logic wake;
	assign wake = smp.current > sleep_exit_current_threshold;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= fgs_pkg::FGS_OFF;
		end else begin
			unique case (mode)
				fgs_pkg::FGS_OFF: begin
					if (ctrl[fgs_pkg::CTRL_EN]) begin
						mode <= ctrl[fgs_pkg::CTRL_SLEEP] ? fgs_pkg::FGS_SLEEP : fgs_pkg::FGS_ACTIVE;
					end
				end
				fgs_pkg::FGS_ACTIVE: begin
					if (!ctrl[fgs_pkg::CTRL_EN]) begin
						mode <= fgs_pkg::FGS_OFF;
					end else if (ctrl[fgs_pkg::CTRL_SLEEP] && !wake) begin
						mode <= fgs_pkg::FGS_SLEEP;
					end
				end
				fgs_pkg::FGS_SLEEP: begin
					if (!ctrl[fgs_pkg::CTRL_EN]) begin
						mode <= fgs_pkg::FGS_OFF;
					end else if (!ctrl[fgs_pkg::CTRL_SLEEP] || (sample_pulse && wake)) begin
						mode <= fgs_pkg::FGS_ACTIVE;
					end
				end
				default: begin
					mode <= fgs_pkg::FGS_OFF;
				end
			endcase
		end
	end

	// ****************************************
	// state of charge update
	// ****************************************
	logic [7:0]  mapped_soc;
	logic [7:0]  soc_limit;
	logic [15:0] eff_capacity;
	logic        temp_ok;
	logic [7:0]  rise;

	fgs_soc_map u_map (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.voltage     (smp.voltage),
		.empty_level (12'h800),
		.soc         (mapped_soc)
	);

	// scales a capacity by (256 - proportion) / 256
	function automatic logic [15:0] fgs_scale(input logic [15:0] cap, input logic [7:0] prop);
		logic [23:0] prod;
		prod = 24'(cap) * 24'(9'h100 - 9'(prop));
		return prod[23:8];
	endfunction

	// ntc voltage falls as temperature rises: window between the limits
	assign temp_ok = ctrl[fgs_pkg::CTRL_TEMP] && ctrl[fgs_pkg::CTRL_THERM]
		&& smp.thermistor <= temp_low_limit && smp.thermistor >= temp_high_limit;

	// effective capacity, reduced more as temperature rises toward the hot limit
	always_comb begin
		eff_capacity = battery_capacity_value;
		if (temp_ok) begin
			eff_capacity = fgs_scale(battery_capacity_value,
				8'((24'(temperature_adjust_proportion) * 24'(temp_low_limit - smp.thermistor))
				/ 24'(temp_low_limit - temp_high_limit + 12'h001)));
		end
	end

	// limit grows with current and shrinks with capacity
	always_comb begin
		logic [27:0] q;
		q = (28'(smp.current) << 8) / 28'({eff_capacity[15:1], 1'b1});
		soc_limit = (q > 28'h00000fe) ? 8'hff : 8'(q) + 8'h01;
	end

	// clamped step toward mapped value; first result from voltage alone
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			soc          <= 8'h00;
			first_update <= 1'b1;
		end else if (mode == fgs_pkg::FGS_OFF) begin
			first_update <= 1'b1;
		end else if (update_pulse) begin
			first_update <= 1'b0;
			if (first_update) begin
				soc <= mapped_soc;
			end else if (mapped_soc > soc) begin
				soc <= (mapped_soc - soc > soc_limit) ? soc + soc_limit : mapped_soc;
			end else begin
				soc <= (soc - mapped_soc > soc_limit) ? soc - soc_limit : mapped_soc;
			end
		end
	end

	// ****************************************
	// charge accumulator and aging
	// ****************************************
	logic [12:0] acm_sum;
	assign rise = (update_pulse && !first_update && smp.charging && mapped_soc > soc)
		? ((mapped_soc - soc > soc_limit) ? soc_limit : mapped_soc - soc) : 8'h00;
	assign acm_sum = 13'(charge_accumulator) + 13'(rise);
	assign acm_overflow = acm_sum >= fgs_pkg::ACM_WRAP;

	// add each charging increase, wrap at full scale
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_accumulator <= 12'h000;
		end else if (wr_hit && avs_address == fgs_pkg::ADDR_ACM) begin
			charge_accumulator <= avs_writedata[11:0]; // host preload, e.g. after a cell swap
		end else begin
			charge_accumulator <= acm_sum[11:0];
		end
	end

	// capacity: host write unless aging adjust owns it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			battery_capacity_value <= fgs_pkg::CAP_RESET;
		end else if (ctrl[fgs_pkg::CTRL_AGE]) begin
			if (acm_overflow) begin
				battery_capacity_value <= fgs_scale(battery_capacity_value, aging_reduction_proportion);
			end
		end else if (wr_hit && avs_address == fgs_pkg::ADDR_CAP) begin
			battery_capacity_value <= avs_writedata[15:0];
		end
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~((wr_hit && avs_address == fgs_pkg::ADDR_IRQ)
				? avs_writedata[IRQ_W-1:0] : '0)) | IRQ_W'(acm_overflow);
		end
	end

	assign accumulator_overflow_irq = irq_status[fgs_pkg::IRQ_ACM];
	assign irq = |(irq_status & irq_mask);

	// ****************************************
	// read data
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !rd_pending) begin
			unique case (avs_address)
				fgs_pkg::ADDR_CTRL: avs_readdata <= {21'h0, mode, ctrl};
				fgs_pkg::ADDR_WAKE: avs_readdata <= {20'h0, sleep_exit_current_threshold};
				fgs_pkg::ADDR_CAP:  avs_readdata <= {eff_capacity, battery_capacity_value};
				fgs_pkg::ADDR_ADJ:  avs_readdata <= {16'h0, temperature_adjust_proportion, aging_reduction_proportion};
				fgs_pkg::ADDR_SOC:  avs_readdata <= {16'h0, mapped_soc, soc};
				fgs_pkg::ADDR_ACM:  avs_readdata <= {20'h0, charge_accumulator};
				fgs_pkg::ADDR_IRQ:  avs_readdata <= {31'h0, irq_status};
				fgs_pkg::ADDR_MASK: avs_readdata <= {31'h0, irq_mask};
				fgs_pkg::ADDR_TLIM: avs_readdata <= {4'h0, temp_high_limit, 4'h0, temp_low_limit};
				default:            avs_readdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

/* File: hdl/fgs_pkg.sv */
package fgs_pkg;
	// ****************************************
	// register map (word addresses)
	// ****************************************
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_WAKE   = 4'h1;
	localparam logic [3:0] ADDR_CAP    = 4'h2;
	localparam logic [3:0] ADDR_ADJ    = 4'h3;
	localparam logic [3:0] ADDR_SOC    = 4'h4;
	localparam logic [3:0] ADDR_ACM    = 4'h5;
	localparam logic [3:0] ADDR_IRQ    = 4'h6;
	localparam logic [3:0] ADDR_MASK   = 4'h7;
	localparam logic [3:0] ADDR_TLIM   = 4'h8;

	// ****************************************
	// control field positions
	// ****************************************
	localparam int CTRL_EN      = 0;
	localparam int CTRL_SLEEP   = 1;
	localparam int CTRL_RATE_LO = 2;
	localparam int CTRL_AGE     = 4;
	localparam int CTRL_TEMP    = 5;
	localparam int CTRL_THERM   = 6;

	localparam int IRQ_ACM = 0;
	localparam int IRQ_NUM = 1;

	// ****************************************
	// reset values and constants
	// ****************************************
	localparam logic [15:0] CAP_RESET   = 16'h0064;
	localparam logic [7:0]  SOC_FULL    = 8'h64;
	localparam logic [12:0] ACM_WRAP    = 13'h1000;
	localparam logic [11:0] TEMP_LO_RST = 12'h0c00;
	localparam logic [11:0] TEMP_HI_RST = 12'h0400;

	// ****************************************
	// timing; periods in tenths of a second
	// ****************************************
	localparam int CLK_HZ         = 25_000_000;
	localparam int TICK_MS        = 100;
	localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
	localparam int ACT_SAMPLE_T   = 10;
	localparam int ACT_UPDATE_T   = 100;
	localparam int SLP_SAMPLE_T   = 75;
	localparam int SLP_UPDATE_T   = 600;

	typedef enum logic [2:0] {
		FGS_OFF    = 3'b001,
		FGS_ACTIVE = 3'b010,
		FGS_SLEEP  = 3'b100
	} fgs_mode_type;

	typedef struct packed {
		logic [11:0] voltage;
		logic [11:0] current;
		logic        charging;
		logic [11:0] thermistor;
	} fgs_sample_type;
endpackage

/* File: hdl/fgs_soc_map.sv */
// maps battery voltage to a percentage through a registered ramp
module fgs_soc_map (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] voltage,
	input  wire logic [11:0] empty_level,
	output logic      [7:0]  soc
);
	logic [11:0] span;
	logic [19:0] scaled;

	// linear ramp above empty level, saturated at full
	always_comb begin
		span = (voltage > empty_level) ? voltage - empty_level : 12'h000;
		scaled = 20'(span) * 20'h00064 / 20'h00400;
	end

	// registered result
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			soc <= 8'h00;
		end else begin
			soc <= (scaled > 20'(fgs_pkg::SOC_FULL)) ? fgs_pkg::SOC_FULL : scaled[7:0];
		end
	end
endmodule
